// ===== hw/baseband_status_pkg.sv
// Constants shared by the status and interrupt unit and its serial port
package baseband_status_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register addresses on the serial control port
    localparam int ADDR_BITS = 8;
    localparam int WORD_BITS = 16;
    localparam int ADC_BITS = 8;
    localparam logic [ADDR_BITS-1:0] ADDR_AUX_ADC = 8'hb4;
    localparam logic [ADDR_BITS-1:0] ADDR_STATUS = 8'hc6;
    localparam logic [ADDR_BITS-1:0] ADDR_PROG = 8'hc8;
    localparam logic [ADDR_BITS-1:0] ADDR_MASK = 8'hce;

    ////////////////////////////////////////////////////////////////////////
    // Status word bit positions
    localparam int B_IRQ = 15;
    localparam int B_INBAND = 13;
    localparam int B_TONESET = 12;
    localparam int B_CTCSS = 11;
    localparam int B_DCS = 10;
    localparam int B_ADC_HI = 9;
    localparam int B_ADC_LO = 8;
    localparam int B_END = 7;
    localparam int B_XFER = 6;
    localparam int B_CRC = 5;
    localparam int B_R2400 = 4;
    localparam int B_R1200 = 3;
    localparam int B_PROG = 0;

    // Field masks and reset values
    localparam logic [WORD_BITS-1:0] WORD_ZERO = 16'h0000;
    localparam logic [WORD_BITS-1:0] STATUS_USED = 16'hbff9;
    localparam logic [WORD_BITS-1:0] TONE_BITS = 16'h2c00;
    localparam logic [WORD_BITS-1:0] IRQ_FIELD = 16'h8000;
    localparam logic [WORD_BITS-1:0] CRC_FIELD = 16'h0020;
    localparam logic [WORD_BITS-1:0] RATE_FIELD = 16'h0018;
    localparam logic [WORD_BITS-1:0] PROG_FIELD = 16'h0001;
    localparam logic [WORD_BITS-1:0] STATUS_RESET = 16'h0001;
    localparam logic [WORD_BITS-1:0] MASK_USED = 16'hffd9;
    localparam logic [WORD_BITS-1:0] MASK_RESET = 16'h0000;
    localparam logic [ADC_BITS-1:0] ADC_RESET = 8'h00;
    localparam logic [ADC_BITS-1:0] ADC_PAD = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Sub-audio status codes and modem data formats
    localparam logic [2:0] SUB_NONE = 3'h0;
    localparam logic [2:0] SUB_DCS = 3'h2;
    localparam logic [2:0] SUB_DCS_INV = 3'h3;
    localparam logic [2:0] SUB_DCS_OFF = 3'h5;
    localparam logic [2:0] SUB_MAINT = 3'h6;
    localparam logic [2:0] FMT_0 = 3'h0;
    localparam logic [2:0] FMT_2 = 3'h2;
    localparam logic [2:0] FMT_3 = 3'h3;
    localparam logic [2:0] FMT_4 = 3'h4;
    localparam logic [2:0] FMT_5 = 3'h5;
    localparam logic [1:0] RATE_1200 = 2'h1;
    localparam logic [1:0] RATE_2400 = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Timing: programming completes within this time at 40 MHz
    localparam int CLK_PERIOD_NS = 25;
    localparam int PROG_TIME_NS = 250000;
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int PROG_CNT_BITS = 14;

    ////////////////////////////////////////////////////////////////////////
    // Serial frame bit counts
    localparam int CNT_BITS = 5;
    localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_BITS-1:0] CNT_ADDR_LAST = 5'h07;
    localparam logic [CNT_BITS-1:0] CNT_ADDR_DONE = 5'h08;
    localparam logic [CNT_BITS-1:0] CNT_ADC_DONE = 5'h10;
    localparam logic [CNT_BITS-1:0] CNT_WORD_LAST = 5'h17;
    localparam logic [CNT_BITS-1:0] CNT_WORD_DONE = 5'h18;
    localparam logic [CNT_BITS-1:0] CNT_MAX = 5'h1f;
    localparam logic [2:0] PIN_IDLE = 3'h4;

    typedef enum {PROG_IDLE, PROG_BUSY} prog_state_type;

endpackage : baseband_status_pkg

// ===== hw/host_serial_port.sv
// Serial control port slave: address byte then 16 or 8 data bits
module host_serial_port
    import baseband_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_csn,
    input wire logic i_sdi,
    input wire logic [WORD_BITS-1:0] i_rd_data,
    output logic o_sdo,
    output logic o_wr_strobe,
    output logic o_rd_done,
    output logic [ADDR_BITS-1:0] o_addr,
    output logic [WORD_BITS-1:0] o_wr_data
);

    ////////////////////////////////////////////////////////////////////////
    // Pins are {csn, sclk, sdi}; the second and third stages feed logic
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [2:0] pin_prev;
    logic [CNT_BITS-1:0] bit_cnt;
    logic [WORD_BITS-1:0] shift_in;
    logic [WORD_BITS-1:0] shift_out;
    logic load_pend;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
            pin_prev <= PIN_IDLE;
        end
        else
        begin
            pin_meta <= {i_csn, i_sclk, i_sdi};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Edge decode on the synchronised copies
    wire cs_active = ~pin_sync[2];
    wire cs_end = pin_sync[2] & ~pin_prev[2];
    wire sclk_rise = pin_sync[1] & ~pin_prev[1];
    wire sclk_fall = ~pin_sync[1] & pin_prev[1];
    wire sdi_bit = pin_sync[0];
    wire is_read = (o_addr == ADDR_AUX_ADC) || (o_addr == ADDR_STATUS);
    wire [CNT_BITS-1:0] read_len =
        (o_addr == ADDR_AUX_ADC) ? CNT_ADC_DONE : CNT_WORD_DONE;
    wire [WORD_BITS-1:0] next_shift_in = {shift_in[WORD_BITS-2:0], sdi_bit};

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencer; read done only for a fully clocked read frame
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            bit_cnt <= CNT_ZERO;
            shift_in <= WORD_ZERO;
            shift_out <= WORD_ZERO;
            o_addr <= ADDR_STATUS;
            o_sdo <= 1'b0;
            o_wr_strobe <= 1'b0;
            o_rd_done <= 1'b0;
            o_wr_data <= WORD_ZERO;
            load_pend <= 1'b0;
        end
        else
        begin
            o_wr_strobe <= 1'b0;
            o_rd_done <= cs_end & is_read & (bit_cnt == read_len);
            load_pend <= cs_active & sclk_rise & (bit_cnt == CNT_ADDR_LAST);
            if (!cs_active)
            begin
                bit_cnt <= CNT_ZERO;
            end
            else if (sclk_rise)
            begin
                shift_in <= next_shift_in;
                if (bit_cnt != CNT_MAX)
                begin
                    bit_cnt <= bit_cnt + 1'b1;
                end
                if (bit_cnt == CNT_ADDR_LAST)
                begin
                    o_addr <= next_shift_in[ADDR_BITS-1:0];
                end
                if (bit_cnt == CNT_WORD_LAST)
                begin
                    o_wr_data <= next_shift_in;
                    o_wr_strobe <= ~is_read;
                end
            end
            else if (load_pend)
            begin
                shift_out <= i_rd_data;
                o_sdo <= i_rd_data[WORD_BITS-1];
            end
            else if (sclk_fall && bit_cnt > CNT_ADDR_DONE)
            begin
                // First data bit holds through the falling edge after address
                shift_out <= {shift_out[WORD_BITS-2:0], 1'b0};
                o_sdo <= shift_out[WORD_BITS-2];
            end
        end
    end

endmodule : host_serial_port

// ===== hw/baseband_status_irq_unit.sv
// Event status word, interrupt mask and aux ADC result of the baseband unit
module baseband_status_irq_unit
    import baseband_status_pkg::*;
#(
    parameter int PROG_WAIT_CYCLES = PROG_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_csn,
    input wire logic i_sdi,
    input wire logic i_dsp_enable,
    input wire logic i_tx_mode,
    input wire logic i_inband_change,
    input wire logic i_ctcss_change,
    input wire logic [2:0] i_subaudio_status,
    input wire logic i_tone_set_done,
    input wire logic i_adc_valid,
    input wire logic [ADC_BITS-1:0] i_adc_data,
    input wire logic [ADC_BITS-1:0] i_adc_high_thr,
    input wire logic [ADC_BITS-1:0] i_adc_low_thr,
    input wire logic i_rx_frame_end,
    input wire logic i_rx_frame_crc_bad,
    input wire logic i_rx_data_ready,
    input wire logic i_tx_data_request,
    input wire logic i_tx_last_bit,
    input wire logic [2:0] i_tx_format,
    input wire logic i_end_flag_enable,
    input wire logic i_block_crc_done,
    input wire logic [2:0] i_rx_format,
    input wire logic i_block_crc_bad,
    input wire logic i_frame_sync,
    input wire logic i_head_crc_ok,
    input wire logic i_type0_enable,
    input wire logic i_rate_2400,
    output logic o_sdo,
    output logic o_host_irq_out_n,
    output logic o_prog_strobe,
    output logic [WORD_BITS-1:0] o_prog_data
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [WORD_BITS-1:0] status_word;
    logic [WORD_BITS-1:0] mask_word;
    logic [ADC_BITS-1:0] adc_result;
    logic [2:0] prev_sub;
    prog_state_type prog_state;
    logic [PROG_CNT_BITS-1:0] prog_count;
    logic [WORD_BITS-1:0] set_vec;
    logic [WORD_BITS-1:0] rd_data;
    logic [ADDR_BITS-1:0] bus_addr;
    logic [WORD_BITS-1:0] bus_wr_data;
    logic bus_wr;
    logic bus_rd_done;

    // Serial control port
    host_serial_port serial_port (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_sclk(i_sclk),
        .i_csn(i_csn),
        .i_sdi(i_sdi),
        .i_rd_data(rd_data),
        .o_sdo(o_sdo),
        .o_wr_strobe(bus_wr),
        .o_rd_done(bus_rd_done),
        .o_addr(bus_addr),
        .o_wr_data(bus_wr_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register decode and read mux
    wire read_clear = bus_rd_done & (bus_addr == ADDR_STATUS);
    wire prog_clear = bus_wr & (bus_addr == ADDR_PROG);
    wire mask_write = bus_wr & (bus_addr == ADDR_MASK);
    wire [WORD_BITS-1:0] adc_word =
        i_dsp_enable ? {adc_result, ADC_PAD} : WORD_ZERO;
    assign rd_data = (bus_addr == ADDR_STATUS) ? status_word :
                     (bus_addr == ADDR_AUX_ADC) ? adc_word : WORD_ZERO;

    ////////////////////////////////////////////////////////////////////////
    // Sub-audio state changes; turn-off tone counts as a DCS event only
    wire sub_changed = (i_subaudio_status != prev_sub);
    wire dcs_involved = (prev_sub == SUB_DCS) || (prev_sub == SUB_DCS_INV) ||
        (prev_sub == SUB_DCS_OFF) || (i_subaudio_status == SUB_DCS) ||
        (i_subaudio_status == SUB_DCS_INV) ||
        (i_subaudio_status == SUB_DCS_OFF);
    wire maint_involved =
        (prev_sub == SUB_MAINT) || (i_subaudio_status == SUB_MAINT);
    wire dcs_evt = sub_changed & dcs_involved;
    wire ctcss_evt = i_ctcss_change | (sub_changed & maint_involved);
    wire rx_mode = ~i_tx_mode;

    // Modem events
    wire rx_end_evt = i_rx_frame_end & rx_mode;
    wire tx_fmt_gated = (i_tx_format == FMT_0) || (i_tx_format == FMT_2) ||
        (i_tx_format == FMT_3);
    wire tx_end_evt = i_tx_last_bit & i_tx_mode &
        (~tx_fmt_gated | i_end_flag_enable);
    wire block_crc_evt = i_block_crc_done & rx_mode &
        ((i_rx_format == FMT_4) || (i_rx_format == FMT_5));
    wire rate_load = i_type0_enable ? i_frame_sync : i_head_crc_ok;
    wire [1:0] rate_code = i_rate_2400 ? RATE_2400 : RATE_1200;
    wire prog_done = (prog_state == PROG_BUSY) &&
        (prog_count == PROG_CNT_BITS'(PROG_WAIT_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////
    // Set sources; tone flags are gated off in transmit
    assign set_vec[B_IRQ] = 1'b0;
    assign set_vec[14] = 1'b0;
    assign set_vec[B_INBAND] = i_inband_change & rx_mode;
    assign set_vec[B_TONESET] = i_tone_set_done;
    assign set_vec[B_CTCSS] = ctcss_evt & rx_mode;
    assign set_vec[B_DCS] = dcs_evt & rx_mode;
    assign set_vec[B_ADC_HI] =
        i_adc_valid & (i_adc_data > i_adc_high_thr);
    assign set_vec[B_ADC_LO] =
        i_adc_valid & (i_adc_data < i_adc_low_thr);
    assign set_vec[B_END] = rx_end_evt | tx_end_evt;
    assign set_vec[B_XFER] = i_rx_data_ready | i_tx_data_request |
        rx_end_evt;
    assign set_vec[B_CRC] = block_crc_evt & i_block_crc_bad;
    assign set_vec[B_R2400] = 1'b0;
    assign set_vec[B_R1200] = 1'b0;
    assign set_vec[2] = 1'b0;
    assign set_vec[1] = 1'b0;
    assign set_vec[B_PROG] = prog_done;

    ////////////////////////////////////////////////////////////////////////
    // Next status: clears first, then sets, so a same-cycle event wins
    wire [WORD_BITS-1:0] kept =
        read_clear ? (status_word & PROG_FIELD) : status_word;
    wire [WORD_BITS-1:0] kept_p =
        prog_clear ? (kept & ~PROG_FIELD) : kept;
    wire [WORD_BITS-1:0] raw = kept_p | set_vec;
    wire [WORD_BITS-1:0] load_sel = (rx_end_evt ? CRC_FIELD : WORD_ZERO) |
        (rate_load ? RATE_FIELD : WORD_ZERO);
    wire [WORD_BITS-1:0] load_val =
        (i_rx_frame_crc_bad ? CRC_FIELD : WORD_ZERO) |
        (WORD_BITS'(rate_code) << B_R1200);
    wire [WORD_BITS-1:0] loaded = (raw & ~load_sel) | (load_val & load_sel);
    wire [WORD_BITS-1:0] gated = loaded & STATUS_USED &
        ~(i_tx_mode ? TONE_BITS : WORD_ZERO);
    wire irq_raise =
        |(gated & ~status_word & mask_word & ~IRQ_FIELD);
    wire [WORD_BITS-1:0] next_status =
        gated | (irq_raise ? IRQ_FIELD : WORD_ZERO);
    wire [WORD_BITS-1:0] next_mask =
        mask_write ? (bus_wr_data & MASK_USED) : mask_word;
    wire next_irq_n = ~(next_status[B_IRQ] & next_mask[B_IRQ]);

    // Status, mask and pin registers
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            status_word <= STATUS_RESET;
            mask_word <= MASK_RESET;
            o_host_irq_out_n <= 1'b1;
            prev_sub <= SUB_NONE;
        end
        else
        begin
            status_word <= next_status;
            mask_word <= next_mask;
            o_host_irq_out_n <= next_irq_n;
            prev_sub <= i_subaudio_status;
        end
    end

    // Aux ADC keeps the latest conversion
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            adc_result <= ADC_RESET;
        end
        else if (i_adc_valid)
        begin
            adc_result <= i_adc_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Programming timer; a new write restarts the wait
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            prog_state <= PROG_IDLE;
            prog_count <= '0;
            o_prog_strobe <= 1'b0;
            o_prog_data <= WORD_ZERO;
        end
        else
        begin
            o_prog_strobe <= prog_clear;
            if (prog_clear)
            begin
                o_prog_data <= bus_wr_data;
            end
            case (prog_state)
                PROG_IDLE:
                begin
                    prog_count <= '0;
                    if (prog_clear)
                    begin
                        prog_state <= PROG_BUSY;
                    end
                end
                PROG_BUSY:
                begin
                    if (prog_clear)
                    begin
                        prog_count <= '0;
                    end
                    else if (prog_done)
                    begin
                        prog_state <= PROG_IDLE;
                    end
                    else
                    begin
                        prog_count <= prog_count + 1'b1;
                    end
                end
                default:
                begin
                    prog_state <= PROG_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence xfer_rise_s;
        set_vec[B_XFER] && mask_word[B_XFER] && !status_word[B_XFER];
    endsequence

    sequence quiet_read_s;
        read_clear && (set_vec == WORD_ZERO) && !rx_end_evt && !rate_load;
    endsequence

    AST_SUMMARY_SET: assert property (xfer_rise_s |=> status_word[B_IRQ])
        else $error("summary bit not set by masked event");
    AST_IRQ_PIN: assert property (o_host_irq_out_n ==
        !(status_word[B_IRQ] && mask_word[B_IRQ]))
        else $error("interrupt pin disagrees with status and gate");
    AST_READ_CLEAR: assert property (quiet_read_s |=>
        (status_word[WORD_BITS-1:1] == 15'h0000))
        else $error("status read did not clear bits 15 to 1");
    AST_PROG_KEEP: assert property (read_clear && !prog_clear &&
        !prog_done |=> status_word[B_PROG] == $past(status_word[B_PROG]))
        else $error("status read changed programming flag");
    AST_RESERVED: assert property ((status_word & ~STATUS_USED) ==
        WORD_ZERO)
        else $error("reserved status bit set");
    AST_TX_TONES: assert property (i_tx_mode |=>
        (status_word & TONE_BITS) == WORD_ZERO)
        else $error("tone flag set in transmit");
    AST_DCS_OFF: assert property (rx_mode && prev_sub == SUB_DCS &&
        i_subaudio_status == SUB_DCS_OFF && !i_ctcss_change &&
        !status_word[B_CTCSS] |=> status_word[B_DCS] &&
        !status_word[B_CTCSS])
        else $error("turn-off tone flagged wrongly");
    AST_MAINT: assert property (rx_mode && prev_sub == SUB_NONE &&
        i_subaudio_status == SUB_MAINT |=> status_word[B_CTCSS])
        else $error("maintenance tone not flagged");
    AST_ADC_HIGH: assert property (i_adc_valid &&
        i_adc_data > i_adc_high_thr |=> status_word[B_ADC_HI])
        else $error("high threshold crossing lost");
    AST_RX_END: assert property (rx_end_evt |=> status_word[B_END] &&
        status_word[B_XFER] &&
        status_word[B_CRC] == $past(i_rx_frame_crc_bad))
        else $error("frame end flags wrong");
    AST_TX_GATE: assert property (tx_end_evt == 1'b0 && i_tx_last_bit &&
        i_tx_mode && !status_word[B_END] |=> !status_word[B_END])
        else $error("end flag set without enable");
    AST_RATE: assert property (rate_load |=>
        status_word[B_R2400:B_R1200] == $past(rate_code))
        else $error("rate field not loaded");
    AST_PROG_CYCLE: assert property (prog_clear && prog_state == PROG_IDLE
        |=> !status_word[B_PROG] ##1 (prog_state == PROG_BUSY))
        else $error("programming write did not start wait");

endmodule : baseband_status_irq_unit

// ===== verif/host_serial_model.sv
// Host controller model that drives the unit's serial control port
module host_serial_model
(
    input wire logic i_clk,
    input wire logic i_sdo,
    output logic o_sclk,
    output logic o_csn,
    output logic o_sdi
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    // Pins idle: clock low, deselected
    initial
    begin
        o_sclk = 1'b0;
        o_csn = 1'b1;
        o_sdi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One frame, address byte then nbits data bits, MSB first; each pin
    // phase lasts 6 clocks because the unit synchronises the pins
    task automatic xfer(input logic [7:0] addr, input logic [15:0] wdata,
        input int nbits, output logic [15:0] rdata);
        logic [23:0] frame;
        frame = {addr, wdata};
        rdata = 16'h0000;
        o_csn = 1'b0;
        for (int i = 0; i < 8 + nbits; i++)
        begin
            o_sdi = frame[23 - i];
            repeat (6) @(negedge i_clk);
            if (i >= 8)
                rdata = {rdata[14:0], i_sdo};
            o_sclk = 1'b1;
            repeat (6) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        // Released data line flips so a stale level never passes for data
        o_sdi = ~o_sdi;
        repeat (2) @(negedge i_clk);
        o_csn = 1'b1;
        repeat (8) @(negedge i_clk);
    endtask : xfer
endmodule : host_serial_model

// ===== verif/baseband_status_irq_unit_tb.sv
// Self-checking bench for the event status and interrupt unit
module baseband_status_irq_unit_tb
    import baseband_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_rst = 1'b1, dsp = 1'b1, tx = 1'b0, crc_bad = 1'b0;
    logic type0 = 1'b0, r2400 = 1'b0, end_en = 1'b0, blk_bad = 1'b0;
    logic [2:0] sub = SUB_NONE, txf = FMT_0, rxf = FMT_4;
    logic [7:0] adc = 8'h00;
    logic [10:0] ev = 11'h000;
    logic sclk, csn, sdi, sdo, irq_n, pstb;
    logic [15:0] pdata;
    int err_total = 0, checked = 0, cycles = 0, strobes = 0;

    ////////////////////////////////////////////////////////////////////////
    // Event pulses ride on ev; thresholds are fixed at 0x80 and 0x20
    baseband_status_irq_unit #(.PROG_WAIT_CYCLES(600)) u_baseband_status_irq_unit
    (
        .i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_csn(csn), .i_sdi(sdi),
        .i_dsp_enable(dsp), .i_tx_mode(tx), .i_inband_change(ev[0]),
        .i_ctcss_change(ev[1]), .i_subaudio_status(sub),
        .i_tone_set_done(ev[2]), .i_adc_valid(ev[3]), .i_adc_data(adc),
        .i_adc_high_thr(8'h80), .i_adc_low_thr(8'h20),
        .i_rx_frame_end(ev[4]), .i_rx_frame_crc_bad(crc_bad),
        .i_rx_data_ready(ev[5]), .i_tx_data_request(ev[6]),
        .i_tx_last_bit(ev[7]), .i_tx_format(txf), .i_end_flag_enable(end_en),
        .i_block_crc_done(ev[8]), .i_rx_format(rxf),
        .i_block_crc_bad(blk_bad), .i_frame_sync(ev[9]),
        .i_head_crc_ok(ev[10]), .i_type0_enable(type0), .i_rate_2400(r2400),
        .o_sdo(sdo), .o_host_irq_out_n(irq_n), .o_prog_strobe(pstb),
        .o_prog_data(pdata)
    );
    host_serial_model u_host_serial_model
    (
        .i_clk(i_clk), .i_sdo(sdo), .o_sclk(sclk), .o_csn(csn), .o_sdi(sdi)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock, hang guard and programming strobe count
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        cycles++;
        strobes += int'(pstb === 1'b1);
        if (cycles == 20000)
        begin
            err_total++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared compare, bus and stimulus tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [7:0] a, input int n, input logic [15:0] e);
        logic [15:0] d;
        u_host_serial_model.xfer(a, 16'h0000, n, d);
        check(d, e);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] junk;
        u_host_serial_model.xfer(a, d, 16, junk);
    endtask : wr
    task automatic pulse(input logic [10:0] m);
        @(negedge i_clk);
        ev = m;
        @(negedge i_clk);
        ev = 11'h000;
        @(negedge i_clk);
    endtask : pulse
    task automatic sub_seq(input logic [2:0] code, input logic [15:0] e);
        sub = code;
        repeat (3) @(negedge i_clk);
        sub = SUB_NONE;
        repeat (3) @(negedge i_clk);
        rd(ADDR_STATUS, 16, e);
    endtask : sub_seq
    task automatic test_done();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_irq();
        rd(ADDR_STATUS, 16, 16'h0001);
        rd(8'h55, 16, 16'h0000);
        wr(ADDR_MASK, 16'h0040);
        pulse(11'h040);
        check({15'h0, irq_n}, 16'h0001);
        rd(ADDR_STATUS, 16, 16'h8041);
        wr(ADDR_MASK, 16'h8040);
        pulse(11'h040);
        check({15'h0, irq_n}, 16'h0000);
        rd(ADDR_STATUS, 16, 16'h8041);
        check({15'h0, irq_n}, 16'h0001);
        rd(ADDR_STATUS, 16, 16'h0001);
    endtask : t_irq
    task automatic t_tones();
        tx = 1'b1;
        pulse(11'h007);
        rd(ADDR_STATUS, 16, 16'h1001);
        tx = 1'b0;
        pulse(11'h003);
        rd(ADDR_STATUS, 16, 16'h2801);
        // Step straight from a DCS code to the turn-off tone
        sub = SUB_DCS;
        repeat (3) @(negedge i_clk);
        sub_seq(SUB_DCS_OFF, 16'h0401);
        sub_seq(SUB_DCS, 16'h0401);
        sub_seq(SUB_MAINT, 16'h0801);
    endtask : t_tones
    task automatic t_adc();
        adc = 8'hf0;
        pulse(11'h008);
        adc = 8'h10;
        pulse(11'h008);
        rd(ADDR_STATUS, 16, 16'h0301);
        rd(ADDR_AUX_ADC, 8, 16'h0010);
        dsp = 1'b0;
        rd(ADDR_AUX_ADC, 8, 16'h0000);
        dsp = 1'b1; // ADC result only reads back with processor on
    endtask : t_adc
    task automatic t_modem();
        pulse(11'h020);
        rd(ADDR_STATUS, 16, 16'h8041);
        crc_bad = 1'b1;
        pulse(11'h010);
        rd(ADDR_STATUS, 16, 16'h80e1);
        blk_bad = 1'b1;
        pulse(11'h100);
        rd(ADDR_STATUS, 16, 16'h0021);
        type0 = 1'b1;
        r2400 = 1'b1;
        pulse(11'h200);
        rd(ADDR_STATUS, 16, 16'h0011);
        type0 = 1'b0;
        r2400 = 1'b0;
        pulse(11'h600);
        rd(ADDR_STATUS, 16, 16'h0009);
        tx = 1'b1;
        pulse(11'h080);
        rd(ADDR_STATUS, 16, 16'h0001);
        end_en = 1'b1;
        pulse(11'h080);
        rd(ADDR_STATUS, 16, 16'h0081);
        end_en = 1'b0;
        txf = FMT_4;
        pulse(11'h080);
        rd(ADDR_STATUS, 16, 16'h0081);
        tx = 1'b0;
    endtask : t_modem
    task automatic t_prog();
        wr(ADDR_MASK, 16'h8021);
        wr(ADDR_PROG, 16'h1234); // Ready flag was read as set
        check(pdata, 16'h1234);
        check(16'(strobes), 16'h0001);
        rd(ADDR_STATUS, 16, 16'h0000);
        repeat (600) @(negedge i_clk);
        check({15'h0, irq_n}, 16'h0000);
        rd(ADDR_STATUS, 16, 16'h8001);
        pulse(11'h100);
        check({15'h0, irq_n}, 16'h0001);
    endtask : t_prog

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        check({15'h0, irq_n}, 16'h0001);
        t_irq();
        t_tones();
        t_adc();
        t_modem();
        t_prog();
        test_done();
    end
endmodule : baseband_status_irq_unit_tb
